// file: pec_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Generator time base with buffered period update.
// ==========================================================================
module pec_gen (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        run,
    input  wire logic        sync_mode,
    input  wire logic        sync_req,
    input  wire logic        prd_wr,
    input  wire logic [15:0] prd_wdata,
    output logic      [15:0] prd_prog,
    output logic             zero_evt,
    output logic             load_evt
);
    logic [15:0] prog_ff;
    logic [15:0] act_ff;
    logic [15:0] cnt_ff;
    logic        pend_ff;
    logic        sync_ff;
    logic        load_ff;
    logic [15:0] nxt_act;
    logic [15:0] nxt_cnt;
    wire         at_zero = run && (cnt_ff == pec_pkg::RST_PRD);
    wire         apply   = at_zero && pend_ff && (!sync_mode || sync_ff);

    assign nxt_act  = apply ? prog_ff : act_ff;
    assign nxt_cnt  = !run ? cnt_ff :
                      at_zero ? ((nxt_act == pec_pkg::RST_PRD) ? pec_pkg::RST_PRD : nxt_act - 16'h0001) :
                      cnt_ff - 16'h0001;
    assign zero_evt = at_zero && (act_ff != pec_pkg::RST_PRD);
    assign load_evt = load_ff;
    assign prd_prog = prog_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_ff <= pec_pkg::RST_PRD;
            act_ff  <= pec_pkg::RST_PRD;
            cnt_ff  <= pec_pkg::RST_PRD;
            pend_ff <= 1'b0;
            sync_ff <= 1'b0;
            load_ff <= 1'b0;
        end else begin
            if (prd_wr) begin
                prog_ff <= prd_wdata;
            end
            act_ff  <= nxt_act;
            cnt_ff  <= nxt_cnt;
            pend_ff <= prd_wr || (pend_ff && !apply);
            sync_ff <= (sync_req && sync_mode) || (sync_ff && !apply);
            load_ff <= at_zero && (nxt_act != pec_pkg::RST_PRD);
        end
    end

    // ======================================================================
    // Checks.
    // ======================================================================
    a_reload_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        zero_evt && !apply |=> cnt_ff == $past(act_ff) - 16'h0001)
        else $error("Counter did not reload to period minus one.");
    a_update_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        act_ff != $past(act_ff) |-> $past(at_zero) && $past(pend_ff))
        else $error("Active period changed away from counter zero.");
    a_latest_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
        prd_wr && pend_ff && !apply |=> pend_ff && (act_ff == $past(act_ff)) && (prog_ff == $past(prd_wdata)))
        else $error("Latest period write was not kept.");
    c_prd_update: cover property (@(posedge sys_clk) disable iff (!reset_n) apply && pend_ff);
endmodule // pec_gen
`default_nettype wire

// file: pec_outcond.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Output fault suppression and polarity.
// ==========================================================================
module pec_outcond (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       fault_active,
    input  wire logic [7:0] fault_suppress,
    input  wire logic [7:0] output_invert,
    input  wire logic [7:0] pwm_in,
    output logic      [7:0] pwm_out
);
    logic [7:0] out_ff;
    logic [7:0] nxt_out;

    genvar i;
    generate
        for (i = 0; i < pec_pkg::NUM_OUT; i++) begin : g_out
            assign nxt_out[i] = ((fault_active && fault_suppress[i]) ? 1'b0 : pwm_in[i])
                                ^ output_invert[i];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_ff <= pec_pkg::RST_BYTE;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign pwm_out = out_ff;

    a_fault_supp: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fault_active && fault_suppress[0] |=> pwm_out[0] == $past(output_invert[0]))
        else $error("Suppressed output not held inactive during fault.");
    a_out_invert: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !fault_active |=> pwm_out == $past(pwm_in ^ output_invert))
        else $error("Output polarity does not follow the inversion bits.");
    c_fault_hold: cover property (@(posedge sys_clk) disable iff (!reset_n)
        fault_active && (fault_suppress != pec_pkg::RST_BYTE));
endmodule // pec_outcond
`default_nettype wire

// file: pec_pkg.sv
`default_nettype none
// ==========================================================================
// Register map, field layout and reset values.
// ==========================================================================
package pec_pkg;
    localparam int NUM_GEN  = 4;
    localparam int NUM_OUT  = 8;
    localparam int NUM_FLT  = 4;
    localparam int NUM_EVT  = 6;
    localparam int PRD_W    = 16;
    localparam int AW       = 8;
    localparam int DW       = 32;
    localparam int ITEN_W   = 12;
    localparam int TRIG_LSB = 6;
    localparam int FLT_LSB  = 4;

    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_SYNC_UPD  = 8'h04;
    localparam logic [7:0] ADDR_IEN_SET   = 8'h08;
    localparam logic [7:0] ADDR_IEN_CLR   = 8'h0C;
    localparam logic [7:0] ADDR_RAW_STAT  = 8'h10;
    localparam logic [7:0] ADDR_MSK_STAT  = 8'h14;
    localparam logic [7:0] ADDR_INVERT    = 8'h18;
    localparam logic [7:0] ADDR_FLT_SUPP  = 8'h1C;
    localparam logic [7:0] ADDR_GEN_LO    = 8'h40;
    localparam logic [7:0] ADDR_GEN_HI    = 8'hBF;

    localparam logic [2:0] GEN_BASE_IDX   = 3'h2;
    localparam logic [2:0] SUB_EN_SET     = 3'h0;
    localparam logic [2:0] SUB_EN_CLR     = 3'h1;
    localparam logic [2:0] SUB_RAW        = 3'h2;
    localparam logic [2:0] SUB_MSK        = 3'h3;
    localparam logic [2:0] SUB_PERIOD     = 3'h4;

    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [11:0] RST_ITEN      = 12'h000;
    localparam logic [5:0]  RST_EVT       = 6'h00;
    localparam logic [15:0] RST_PRD       = 16'h0000;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
endpackage
`default_nettype wire

// file: pec_top.sv
// Summary of operation
// - Clearing a generator enable bit masks that interrupt or trigger source.
// - Setting a generator enable bit unmasks that source, other bits untouched.
// - Six events per generator, each with interrupt and trigger enables.
// - Period equals clock ticks between successive counter-zero pulses.
// - Period read returns the programmed value, not the active one.
// - A newer period write replaces an unapplied pending one.
// - Module enable has four generator and four fault bits; clear masks.
// - Setting a module enable bit unmasks that interrupt to the processor.
// - Raw and masked module status are both readable.
// - Suppress bit forces its output inactive while a fault is active.
// - Invert bit makes its output active low.
// - Writing one clears a latched generator event; zero leaves it.
// - Period updates apply at counter zero, after sync in sync mode.
`timescale 1ns/1ps
`default_nettype none
module pec_top (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [15:0] cmp_evt,
    input  wire logic [3:0]  fault_in,
    input  wire logic [7:0]  pwm_in,
    output logic      [7:0]  pwm_out,
    output logic      [3:0]  trig_out,
    output logic             irq
);
    // ======================================================================
    // Module-level registers.
    // ======================================================================
    logic [7:0]  ctrl_ff;
    logic [7:0]  ien_ff;
    logic [3:0]  flt_ris_ff;
    logic [7:0]  inv_ff;
    logic [7:0]  supp_ff;
    logic [31:0] rdata_ff;
    logic [3:0]  trig_ff;
    logic [3:0]  sync_req;
    logic [3:0]  gen_irq;
    logic [3:0]  trig_nxt;
    logic [7:0]  mod_ris;
    logic [7:0]  mod_mis;
    logic [3:0]  nxt_flt_ris;

    logic [11:0] iten_ff  [4];
    logic [5:0]  ris_ff   [4];
    logic [5:0]  evt      [4];
    logic [5:0]  mis      [4];
    logic [15:0] prd_prog [4];
    logic [31:0] gen_rd   [4];

    // ======================================================================
    // Address decode.
    // ======================================================================
    wire       wr_ctrl  = reg_wr && (reg_addr == pec_pkg::ADDR_CTRL);
    wire       wr_sync  = reg_wr && (reg_addr == pec_pkg::ADDR_SYNC_UPD);
    wire       wr_iset  = reg_wr && (reg_addr == pec_pkg::ADDR_IEN_SET);
    wire       wr_iclr  = reg_wr && (reg_addr == pec_pkg::ADDR_IEN_CLR);
    wire       wr_mstat = reg_wr && (reg_addr == pec_pkg::ADDR_MSK_STAT);
    wire       wr_inv   = reg_wr && (reg_addr == pec_pkg::ADDR_INVERT);
    wire       wr_supp  = reg_wr && (reg_addr == pec_pkg::ADDR_FLT_SUPP);
    wire       gen_hit  = (reg_addr >= pec_pkg::ADDR_GEN_LO) && (reg_addr <= pec_pkg::ADDR_GEN_HI);
    wire [2:0] gen_sel  = reg_addr[7:5] - pec_pkg::GEN_BASE_IDX;
    wire [2:0] gen_sub  = reg_addr[4:2];
    wire       word_ok  = (reg_addr[1:0] == 2'h0);
    wire       fault_active = |fault_in;

    assign sync_req    = wr_sync ? reg_wdata[3:0] : 4'h0;
    assign nxt_flt_ris = fault_in | (flt_ris_ff & ~(wr_mstat ? reg_wdata[7:4] : 4'h0));
    assign mod_ris     = {flt_ris_ff, gen_irq};
    assign mod_mis     = mod_ris & ien_ff;
    assign irq         = |mod_mis;

    // ======================================================================
    // Generators.
    // ======================================================================
    genvar g;
    generate
        for (g = 0; g < pec_pkg::NUM_GEN; g++) begin : g_gen
            wire        sel     = reg_wr && gen_hit && word_ok && (gen_sel == 3'(g));
            wire        wr_eset = sel && (gen_sub == pec_pkg::SUB_EN_SET);
            wire        wr_eclr = sel && (gen_sub == pec_pkg::SUB_EN_CLR);
            wire        wr_msk  = sel && (gen_sub == pec_pkg::SUB_MSK);
            wire        wr_prd  = sel && (gen_sub == pec_pkg::SUB_PERIOD);
            wire [11:0] set_m   = wr_eset ? reg_wdata[11:0] : pec_pkg::RST_ITEN;
            wire [11:0] clr_m   = wr_eclr ? reg_wdata[11:0] : pec_pkg::RST_ITEN;
            wire [5:0]  w1c_m   = wr_msk ? reg_wdata[5:0] : pec_pkg::RST_EVT;
            wire        zero_e;
            wire        load_e;

            pec_gen u_gen (
                .sys_clk   (sys_clk),
                .reset_n   (reset_n),
                .run       (ctrl_ff[g]),
                .sync_mode (ctrl_ff[g+4]),
                .sync_req  (sync_req[g]),
                .prd_wr    (wr_prd),
                .prd_wdata (reg_wdata[15:0]),
                .prd_prog  (prd_prog[g]),
                .zero_evt  (zero_e),
                .load_evt  (load_e)
            );

            assign evt[g]      = {cmp_evt[4*g+3 -: 4], load_e, zero_e};
            assign mis[g]      = ris_ff[g] & iten_ff[g][5:0];
            assign gen_irq[g]  = |mis[g];
            assign trig_nxt[g] = |(evt[g] & iten_ff[g][11:6]);
            assign gen_rd[g]   = (gen_sub == pec_pkg::SUB_EN_SET) ? {20'h0, iten_ff[g]} :
                                 (gen_sub == pec_pkg::SUB_EN_CLR) ? {20'h0, iten_ff[g]} :
                                 (gen_sub == pec_pkg::SUB_RAW)    ? {26'h0, ris_ff[g]} :
                                 (gen_sub == pec_pkg::SUB_MSK)    ? {26'h0, mis[g]} :
                                 (gen_sub == pec_pkg::SUB_PERIOD) ? {16'h0, prd_prog[g]} :
                                 pec_pkg::RST_WORD;

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    iten_ff[g] <= pec_pkg::RST_ITEN;
                    ris_ff[g]  <= pec_pkg::RST_EVT;
                end else begin
                    iten_ff[g] <= (iten_ff[g] | set_m) & ~clr_m;
                    ris_ff[g]  <= evt[g] | (ris_ff[g] & ~w1c_m);
                end
            end
        end
    endgenerate

    // ======================================================================
    // Output conditioning.
    // ======================================================================
    pec_outcond u_out (
        .sys_clk        (sys_clk),
        .reset_n        (reset_n),
        .fault_active   (fault_active),
        .fault_suppress (supp_ff),
        .output_invert  (inv_ff),
        .pwm_in         (pwm_in),
        .pwm_out        (pwm_out)
    );

    // ======================================================================
    // Read mux.
    // ======================================================================
    wire [31:0] rd_mux = !word_ok                                ? pec_pkg::RST_WORD :
                         (reg_addr == pec_pkg::ADDR_CTRL)        ? {24'h0, ctrl_ff} :
                         (reg_addr == pec_pkg::ADDR_IEN_SET)     ? {24'h0, ien_ff} :
                         (reg_addr == pec_pkg::ADDR_IEN_CLR)     ? {24'h0, ien_ff} :
                         (reg_addr == pec_pkg::ADDR_RAW_STAT)    ? {24'h0, mod_ris} :
                         (reg_addr == pec_pkg::ADDR_MSK_STAT)    ? {24'h0, mod_mis} :
                         (reg_addr == pec_pkg::ADDR_INVERT)      ? {24'h0, inv_ff} :
                         (reg_addr == pec_pkg::ADDR_FLT_SUPP)    ? {24'h0, supp_ff} :
                         gen_hit                                 ? gen_rd[gen_sel[1:0]] :
                         pec_pkg::RST_WORD;

    // ======================================================================
    // Module registers.
    // ======================================================================
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff    <= pec_pkg::RST_BYTE;
            ien_ff     <= pec_pkg::RST_BYTE;
            flt_ris_ff <= 4'h0;
            inv_ff     <= pec_pkg::RST_BYTE;
            supp_ff    <= pec_pkg::RST_BYTE;
            rdata_ff   <= pec_pkg::RST_WORD;
            trig_ff    <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata[7:0];
            end
            if (wr_inv) begin
                inv_ff <= reg_wdata[7:0];
            end
            if (wr_supp) begin
                supp_ff <= reg_wdata[7:0];
            end
            ien_ff     <= (ien_ff | (wr_iset ? reg_wdata[7:0] : 8'h00))
                          & ~(wr_iclr ? reg_wdata[7:0] : 8'h00);
            flt_ris_ff <= nxt_flt_ris;
            rdata_ff   <= reg_rd ? rd_mux : pec_pkg::RST_WORD;
            trig_ff    <= trig_nxt;
        end
    end

    assign reg_rdata = rdata_ff;
    assign trig_out  = trig_ff;

    // ======================================================================
    // Checks.
    // ======================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_en_set_bits: assert property (
        reg_wr && reg_addr == 8'h40 |=> iten_ff[0] == ($past(iten_ff[0]) | $past(reg_wdata[11:0])))
        else $error("Enable set did not OR in the written bits.");
    a_en_clr_bits: assert property (
        reg_wr && reg_addr == 8'h44 |=> (iten_ff[0] & $past(reg_wdata[11:0])) == 12'h000)
        else $error("Enable clear left a written bit set.");
    a_mask_and: assert property (
        mis[1] == (ris_ff[1] & iten_ff[1][5:0]))
        else $error("Masked event status is not raw AND enable.");
    a_raw_latch: assert property (
        evt[1] != 6'h00 |=> (ris_ff[1] & $past(evt[1])) == $past(evt[1]))
        else $error("Raw event bit failed to latch.");
    a_w1c_clear: assert property (
        reg_wr && reg_addr == 8'h6C && reg_wdata[2] && !evt[1][2] |=> !ris_ff[1][2])
        else $error("Write one did not clear the event bit.");
    a_w0_keep: assert property (
        reg_wr && reg_addr == 8'h6C && !reg_wdata[2] && ris_ff[1][2] |=> ris_ff[1][2])
        else $error("Write zero cleared an event bit.");
    a_gen_irq_or: assert property (
        mod_ris[1] == |(ris_ff[1] & iten_ff[1][5:0]))
        else $error("Generator interrupt is not OR of masked events.");
    a_ien_set: assert property (
        reg_wr && reg_addr == 8'h08 |=> (ien_ff & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]))
        else $error("Module enable set did not take effect.");
    a_irq_level: assert property (
        irq == |(mod_ris & ien_ff))
        else $error("Interrupt line disagrees with masked status.");
    a_rd_masked: assert property (
        reg_rd && reg_addr == 8'h14 && !reg_wr |=> reg_rdata == {24'h0, $past(mod_mis)})
        else $error("Masked status read returned the wrong value.");
    a_period_read: assert property (
        reg_wr && reg_addr == 8'h50 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h50 && !reg_wr
        |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 3)})
        else $error("Period read did not return the programmed value.");

    c_irq_rise: cover property (!irq ##1 irq);
    c_trig_pulse: cover property (trig_out != 4'h0);
    c_w1c_clear: cover property (irq ##1 reg_wr && reg_addr == pec_pkg::ADDR_MSK_STAT ##1 !irq);
endmodule // pec_top
`default_nettype wire

// file: pwm_event_and_output_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the event, interrupt and output logic.
// ==========================================================================
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module pwm_event_and_output_control_bench;
    logic        sys_clk     = 1'b0;
    logic        reset_n     = 1'b0;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0000_0000;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] cmp_evt     = 16'h0000;
    logic [3:0]  fault_in    = 4'h0;
    logic [7:0]  pwm_in      = 8'h00;
    logic [7:0]  pwm_out;
    logic [3:0]  trig_out;
    logic        irq;
    logic [31:0] d;
    int          n;
    int          miscompares = 0;
    int          comparisons = 0;

    pec_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_evt(cmp_evt),
                   .fault_in(fault_in), .pwm_in(pwm_in), .pwm_out(pwm_out), .trig_out(trig_out), .irq(irq));

    always #4 sys_clk = ~sys_clk;

    // ======================================================================
    // Bus and stimulus tasks.
    // ======================================================================
    function automatic logic [7:0] gb(input int g);
        return 8'(32'h40 + 32 * g);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic evt(input logic [15:0] e);
        @(posedge sys_clk);
        cmp_evt <= e;
        @(posedge sys_clk);
        cmp_evt <= 16'h0000;
        #1;
    endtask

    task automatic wait_trig(input int g, output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1 cnt++;
        end while (trig_out[g] !== 1'b1 && cnt < 500);
        if (cnt >= 500) begin
            miscompares++;
            finish_test();
        end
    endtask

    task automatic finish_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ======================================================================
    // Scenarios.
    // ======================================================================
    task automatic t_reset();
        rd(pec_pkg::ADDR_IEN_SET, d);  `CHK(d, 32'h0000_0000)
        rd(pec_pkg::ADDR_INVERT, d);   `CHK(d, 32'h0000_0000)
        rd(8'h20, d);                  `CHK(d, 32'h0000_0000)
        rd(8'h41, d);                  `CHK(d, 32'h0000_0000)
        `CHK({irq, trig_out, pwm_out}, 13'h0000)
    endtask

    task automatic t_enables();
        for (int g = 0; g < 4; g++) begin
            wr(gb(g), 32'h0000_000F | (32'h800 >> g));
            wr(gb(g) + 8'h04, 32'h1 << g);
        end
        for (int g = 0; g < 4; g++) begin
            rd(gb(g), d);              `CHK(d, (32'h0000_000F | (32'h800 >> g)) & ~(32'h1 << g))
        end
        for (int g = 0; g < 4; g++) begin
            wr(gb(g) + 8'h04, 32'h0000_0FFF);
            rd(gb(g), d);              `CHK(d, 32'h0000_0000)
        end
    endtask

    task automatic t_events();
        wr(pec_pkg::ADDR_IEN_SET, 32'h0000_0002);
        wr(gb(1), 32'h0000_0100);
        evt(16'h0010);                 `CHK(trig_out, 4'b0010)
        rd(gb(1) + 8'h08, d);          `CHK(d, 32'h0000_0004)
        rd(gb(1) + 8'h0C, d);          `CHK(d, 32'h0000_0000)
        `CHK(irq, 1'b0)
        wr(gb(1) + 8'h04, 32'h0000_0100);
        evt(16'h0010);                 `CHK(trig_out, 4'b0000)
        wr(gb(1), 32'h0000_0004);
        rd(gb(1) + 8'h0C, d);          `CHK(d, 32'h0000_0004)
        rd(pec_pkg::ADDR_RAW_STAT, d); `CHK(d, 32'h0000_0002)
        `CHK(irq, 1'b1)
        wr(pec_pkg::ADDR_IEN_CLR, 32'h0000_0002);
        rd(pec_pkg::ADDR_MSK_STAT, d); `CHK(d, 32'h0000_0000)
        rd(pec_pkg::ADDR_RAW_STAT, d); `CHK(d, 32'h0000_0002)
        `CHK(irq, 1'b0)
        wr(pec_pkg::ADDR_IEN_SET, 32'h0000_0002);
        wr(gb(1) + 8'h0C, 32'h0000_0000);
        rd(gb(1) + 8'h08, d);          `CHK(d, 32'h0000_0004)
        wr(gb(1) + 8'h0C, 32'h0000_0004);
        rd(gb(1) + 8'h08, d);          `CHK(d, 32'h0000_0000)
        `CHK(irq, 1'b0)
    endtask

    task automatic t_outputs();
        wr(pec_pkg::ADDR_INVERT, 32'h0000_000F);
        wr(pec_pkg::ADDR_FLT_SUPP, 32'h0000_0033);
        wr(pec_pkg::ADDR_IEN_SET, 32'h0000_0040);
        @(posedge sys_clk);
        pwm_in <= 8'hA5;
        repeat (2) @(posedge sys_clk);
        #1 `CHK(pwm_out, 8'hAA)
        @(posedge sys_clk);
        fault_in <= 4'h4;
        repeat (2) @(posedge sys_clk);
        #1 `CHK(pwm_out, 8'h8B)
        rd(pec_pkg::ADDR_MSK_STAT, d); `CHK(d, 32'h0000_0040)
        `CHK(irq, 1'b1)
        @(posedge sys_clk);
        fault_in <= 4'h0;
        wr(pec_pkg::ADDR_MSK_STAT, 32'h0000_0040);
        rd(pec_pkg::ADDR_RAW_STAT, d); `CHK(d, 32'h0000_0000)
        `CHK({irq, pwm_out}, 9'h0AA)
    endtask

    task automatic t_period();
        wr(gb(0), 32'h0000_0040);
        wr(gb(0) + 8'h10, 32'd40);
        wr(pec_pkg::ADDR_CTRL, 32'h0000_0001);
        wait_trig(0, n);
        wait_trig(0, n);               `CHK(n, 40)
        wr(gb(0) + 8'h10, 32'd200);
        wr(gb(0) + 8'h10, 32'd12);
        rd(gb(0) + 8'h10, d);          `CHK(d, 32'd12)
        wait_trig(0, n);
        wait_trig(0, n);               `CHK(n, 12)
        wr(pec_pkg::ADDR_CTRL, 32'h0000_0011);
        wr(gb(0) + 8'h10, 32'd20);
        wait_trig(0, n);
        wait_trig(0, n);               `CHK(n, 12)
        wr(pec_pkg::ADDR_SYNC_UPD, 32'h0000_0001);
        wait_trig(0, n);
        wait_trig(0, n);               `CHK(n, 20)
    endtask

    // ======================================================================
    // Main sequence.
    // ======================================================================
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_enables();
        t_events();
        t_outputs();
        t_period();
        finish_test();
    end
endmodule // pwm_event_and_output_control_bench
`default_nettype wire
